// ### acbr_pkg.sv
// Purpose: Shared constants and types of the control byte receiver
// Assumes: Control byte is 8 bits, sent MSB first; the MSB is the start bit
// Notes:   Field positions are bit indices within the control byte
package acbr_pkg;
  // ==========================================================
  // Control byte layout
  localparam int         CTRL_W       = 8;
  localparam int         START_POS    = 7;
  localparam int         SEL_HI       = 6;
  localparam int         SEL_LO       = 4;
  localparam int         POL_POS      = 3;
  localparam int         CFG_POS      = 2;
  localparam int         MODE_HI      = 1;
  localparam int         MODE_LO      = 0;
  // ==========================================================
  // Link bit counts
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_ONE      = 4'h1;
  localparam logic [3:0] CNT_TRACK    = 4'h5;
  localparam logic [3:0] CNT_LAST     = 4'h7;
  // ==========================================================
  // Buffering
  localparam int         FIFO_DEPTH   = 16;
  // ==========================================================
  // Reset values
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [2:0] CHAN_RST     = 3'h0;
  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    ACBR_HUNT  = 2'h1,
    ACBR_SHIFT = 2'h2
  } acbr_link_st_t;

  typedef enum logic [1:0]
  {
    ACBR_FULL_PD  = 2'h0,
    ACBR_FAST_PD  = 2'h1,
    ACBR_INT_CLK  = 2'h2,
    ACBR_EXT_CLK  = 2'h3
  } acbr_mode_t;
endpackage

// ### acbr_receiver.sv
// Purpose: Serial control byte receiver with decode of channel and mode
// Assumes: sclk idles low, data sampled on sclk rising edge, cs_n active low
// Notes:   Link logic runs on sclk; decoded settings live on sys_clk
//
// Functional notes
// - With chip select low, shift data in on each serial clock rise.
// - Zero bits before the start bit are ignored and change nothing.
// - First one bit is control bit 7; rest follow MSB first.
// - Bits 6 to 4 form the channel select field.
// - Bit 3 one means unipolar, zero means bipolar.
// - Bit 2 one means single-ended, zero means differential.
// - Bits 1 and 0 give the power-down or conversion clock mode.
// - Single-ended: common return negative, codes map to channels 0 to 7.
// - Differential: code picks pair; high select bit makes odd channel positive.
// - Data out changes on falling edges; released while chip select high.
// - Track after fifth bit falling edge; hold after eighth bit falling edge.
// - Conversion starts on the falling edge after the eighth bit.
`timescale 1ns/100ps

module acbr_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready  = (count_r != FULL_CNT);
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop)
      begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

module acbr_receiver (
  // System clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Serial link
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       din,
  output logic            dout_o,
  output logic            dout_oe,
  // Track/hold and conversion timing, sclk domain
  output logic            track_o,
  output logic            hold_o,
  output logic            conv_start_o,
  // Decoded settings, sys_clk domain
  input  wire logic       cfg_ready,
  output logic            cfg_valid_r,
  output logic [2:0]      pos_chan_r,
  output logic [2:0]      neg_chan_r,
  output logic            neg_common_r,
  output logic            polarity_select_r,
  output logic            input_config_select_r,
  output logic [1:0]      power_clock_mode_r,
  output logic            overflow_r
);
  // ==========================================================
  // Link side, sclk domain
  acbr_pkg::acbr_link_st_t link_st_r;
  logic [3:0]              bit_cnt_r;
  logic [6:0]              shift_r;
  logic                    byte_done_r;
  logic [7:0]              byte_r;
  logic                    byte_tgl_r;
  logic                    link_clr;
  logic                    last_bit;

  // Frame end or system reset clears the link state
  assign link_clr = cs_n | rst;
  assign last_bit = (link_st_r == acbr_pkg::ACBR_SHIFT) && (bit_cnt_r == acbr_pkg::CNT_LAST);

  always_ff @(posedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      link_st_r   <= acbr_pkg::ACBR_HUNT;
      bit_cnt_r   <= acbr_pkg::CNT_ZERO;
      shift_r     <= '0;
      byte_done_r <= 1'b0;
    end
    else
    begin
      byte_done_r <= last_bit;
      unique case (link_st_r)
        acbr_pkg::ACBR_HUNT:
        begin
          if (din)
          begin
            link_st_r <= acbr_pkg::ACBR_SHIFT;
            bit_cnt_r <= acbr_pkg::CNT_ONE;
            shift_r   <= 7'h01;
          end
        end
        acbr_pkg::ACBR_SHIFT:
        begin
          shift_r   <= {shift_r[5:0], din};
          bit_cnt_r <= bit_cnt_r + 1'b1;
          if (last_bit)
          begin
            link_st_r <= acbr_pkg::ACBR_HUNT;
            bit_cnt_r <= acbr_pkg::CNT_ZERO;
          end
        end
      endcase
    end
  end

  // Completed byte is held here until the next one, so it is stable for the crossing
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      byte_r     <= acbr_pkg::BYTE_RST;
      byte_tgl_r <= 1'b0;
    end
    else if (!cs_n && last_bit)
    begin
      byte_r     <= {shift_r, din};
      byte_tgl_r <= ~byte_tgl_r;
    end
  end

  // ==========================================================
  // Falling edge outputs
  always_ff @(negedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      dout_o       <= 1'b0;
      dout_oe      <= 1'b0;
      track_o      <= 1'b0;
      hold_o       <= 1'b0;
      conv_start_o <= 1'b0;
    end
    else
    begin
      dout_o       <= 1'b0;
      dout_oe      <= 1'b1;
      conv_start_o <= byte_done_r;
      if (byte_done_r)
      begin
        track_o <= 1'b0;
        hold_o  <= 1'b1;
      end
      else if (link_st_r == acbr_pkg::ACBR_SHIFT && bit_cnt_r == acbr_pkg::CNT_TRACK)
      begin
        track_o <= 1'b1;
        hold_o  <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Crossing into sys_clk
  logic tgl_meta_r;
  logic tgl_sync_r;
  logic tgl_seen_r;
  logic byte_evt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic pop;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tgl_meta_r <= 1'b0;
      tgl_sync_r <= 1'b0;
      tgl_seen_r <= 1'b0;
    end
    else
    begin
      tgl_meta_r <= byte_tgl_r;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end

  assign byte_evt = tgl_sync_r ^ tgl_seen_r;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      overflow_r <= 1'b0;
    end
    else if (byte_evt && !fifo_in_ready)
    begin
      overflow_r <= 1'b1;
    end
  end

  acbr_fifo #(
    .W (acbr_pkg::CTRL_W),
    .D (acbr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .rst       (rst),
    .in_valid  (byte_evt),
    .in_ready  (fifo_in_ready),
    .in_data   (byte_r),
    .out_valid (fifo_out_valid),
    .out_ready (cfg_ready),
    .out_data  (fifo_out_data)
  );

  // ==========================================================
  // Decode and latch
  assign pop = fifo_out_valid && cfg_ready;

  // Positive input index; same form for both input configurations
  function automatic logic [2:0] pos_of(input logic [2:0] sel);
    pos_of = {sel[1], sel[0], sel[2]};
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cfg_valid_r           <= 1'b0;
      pos_chan_r            <= acbr_pkg::CHAN_RST;
      neg_chan_r            <= acbr_pkg::CHAN_RST;
      neg_common_r          <= 1'b1;
      polarity_select_r     <= 1'b0;
      input_config_select_r <= 1'b1;
      power_clock_mode_r    <= acbr_pkg::ACBR_INT_CLK;
    end
    else
    begin
      cfg_valid_r <= pop;
      if (pop)
      begin
        pos_chan_r            <= pos_of(fifo_out_data[acbr_pkg::SEL_HI:acbr_pkg::SEL_LO]);
        polarity_select_r     <= fifo_out_data[acbr_pkg::POL_POS];
        input_config_select_r <= fifo_out_data[acbr_pkg::CFG_POS];
        power_clock_mode_r    <= fifo_out_data[acbr_pkg::MODE_HI:acbr_pkg::MODE_LO];
        neg_common_r          <= fifo_out_data[acbr_pkg::CFG_POS];
        neg_chan_r            <= pos_of(fifo_out_data[acbr_pkg::SEL_HI:acbr_pkg::SEL_LO])
                                 ^ 3'h1;
      end
    end
  end
endmodule

// ### acbr_checker.sv
// Purpose: Port assertions for the control byte receiver
// Assumes: sclk stands still between frames
// Notes:   Link checks are off while cs_n is high
`timescale 1ns/100ps
module acbr_checker (
  // Clocks and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Link
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       dout_oe,
  input wire logic       track_o,
  input wire logic       hold_o,
  input wire logic       conv_start_o,
  // Settings
  input wire logic       cfg_ready,
  input wire logic       cfg_valid_r,
  input wire logic [2:0] pos_chan_r,
  input wire logic [2:0] neg_chan_r,
  input wire logic       neg_common_r,
  input wire logic       input_config_select_r,
  input wire logic [1:0] power_clock_mode_r,
  input wire logic       overflow_r
);
  // ==========================================================
  // Link domain
  property p_track_span;
    @(negedge sclk) disable iff (rst || cs_n)
    $rose(track_o) |-> !hold_o ##1 track_o ##1 track_o ##1 (hold_o && !track_o && conv_start_o);
  endproperty
  a_track_span: assert property (p_track_span) else $error("track to hold span wrong");
  property p_start_one;
    @(negedge sclk) disable iff (rst || cs_n)
    conv_start_o |=> !conv_start_o && hold_o;
  endproperty
  a_start_one: assert property (p_start_one) else $error("conversion start not one period");
  // ==========================================================
  // System domain
  property p_oe_release;
    @(posedge sys_clk) disable iff (rst) cs_n |-> !dout_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("data out driven while deselected");
  property p_sgl;
    @(posedge sys_clk) disable iff (rst) cfg_valid_r && input_config_select_r |-> neg_common_r;
  endproperty
  a_sgl: assert property (p_sgl) else $error("single ended without common return");
  property p_dif;
    @(posedge sys_clk) disable iff (rst) cfg_valid_r && !input_config_select_r
      |-> !neg_common_r && neg_chan_r == {pos_chan_r[2:1], !pos_chan_r[0]};
  endproperty
  a_dif: assert property (p_dif) else $error("differential pair wrong");
  property p_hold_set;
    @(posedge sys_clk) disable iff (rst)
    !cfg_valid_r |-> $stable(pos_chan_r) && $stable(power_clock_mode_r) && $stable(input_config_select_r);
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("settings changed without update");
  property p_pop_ready;
    @(posedge sys_clk) disable iff (rst) cfg_valid_r |-> $past(cfg_ready);
  endproperty
  a_pop_ready: assert property (p_pop_ready) else $error("update without ready");
  property p_ovf_sticky;
    @(posedge sys_clk) disable iff (rst) overflow_r |=> overflow_r;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag cleared");
  c_conv: cover property (@(negedge sclk) disable iff (rst || cs_n) $rose(conv_start_o));
  c_ovf: cover property (@(posedge sys_clk) disable iff (rst) $rose(overflow_r));
  c_dif: cover property (@(posedge sys_clk) disable iff (rst) cfg_valid_r && !input_config_select_r);
endmodule

bind acbr_receiver acbr_checker i_chk (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
  .dout_oe(dout_oe), .track_o(track_o), .hold_o(hold_o), .conv_start_o(conv_start_o),
  .cfg_ready(cfg_ready), .cfg_valid_r(cfg_valid_r), .pos_chan_r(pos_chan_r), .neg_chan_r(neg_chan_r),
  .neg_common_r(neg_common_r), .input_config_select_r(input_config_select_r),
  .power_clock_mode_r(power_clock_mode_r), .overflow_r(overflow_r));

// ### acbr_host_model.sv
// Purpose: Serial host that sends control bytes in mode zero
// Assumes: 30 ns serial clock, running only inside frames
// Notes:   Data line shows inverted last bit once released
`timescale 1ns/100ps
module acbr_host_model (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic din
);
  initial
  begin
    // Scheduled late so the receiver's reset processes see the first edge
    sclk <= 1'b0;
    cs_n <= 1'b1;
    din  <= 1'b1;
  end
  // Data set while sclk low, taken by the receiver on the rise
  task automatic put_bit(input logic b);
    din = b;
    #15 sclk = 1'b1;
    #15 sclk = 1'b0;
  endtask
  // Leading zeros, bytes MSB first, two result bytes; cut > 0 aborts after cut bits
  task automatic frame(input logic [7:0] q[$], input int nz, input int cut);
    cs_n = 1'b0;
    #7;
    repeat (nz) put_bit(1'b0);
    foreach (q[i])
      for (int k = 7; k >= 0; k--)
        if (cut == 0 || 7 - k < cut)
          put_bit(q[i][k]);
    if (cut == 0)
      repeat (16) put_bit(1'b0);
    cs_n = 1'b1;
    din = !din;
    #41;
  endtask
endmodule

// ### acbr_receiver_tb_top.sv
// Purpose: Self-checking bench for the control byte receiver
// Assumes: Settings are compared against a queue of decoded bytes
// Notes:   Random lead zeros and ready stalls from an xorshift
`timescale 1ns/100ps
module acbr_receiver_tb_top;
  logic        sys_clk;
  logic        rst;
  logic        sclk, cs_n, din, dout_o, dout_oe, track_o, hold_o, conv_start_o;
  logic        cfg_ready = 1'b0;
  logic        stall = 1'b0;
  logic        cfg_valid_r, neg_common_r, polarity_select_r, input_config_select_r, overflow_r;
  logic [2:0]  pos_chan_r, neg_chan_r;
  logic [1:0]  power_clock_mode_r;
  logic [10:0] seen, exp_q[$];
  logic [7:0]  q[$];
  logic [31:0] seed = 32'h1C;
  logic [31:0] r;
  int          n_fail = 0;
  int          n_compared = 0;
  int          n_conv = 0;

  assign seen = {pos_chan_r, input_config_select_r ? 3'h0 : neg_chan_r, neg_common_r, polarity_select_r,
                 input_config_select_r, power_clock_mode_r};

  acbr_host_model i_host (.sclk(sclk), .cs_n(cs_n), .din(din));
  acbr_receiver i_dut (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o),
    .dout_oe(dout_oe), .track_o(track_o), .hold_o(hold_o), .conv_start_o(conv_start_o), .cfg_ready(cfg_ready),
    .cfg_valid_r(cfg_valid_r), .pos_chan_r(pos_chan_r), .neg_chan_r(neg_chan_r), .neg_common_r(neg_common_r),
    .polarity_select_r(polarity_select_r), .input_config_select_r(input_config_select_r),
    .power_clock_mode_r(power_clock_mode_r), .overflow_r(overflow_r));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected settings worked out with integers
  function automatic logic [10:0] dec(input logic [7:0] b);
    int p;
    int n;
    p = 4 * b[5] + 2 * b[4] + b[6];
    n = b[2] ? 0 : 4 * b[5] + 2 * b[4] + (1 - b[6]);
    return {p[2:0], n[2:0], b[2], b[3], b[2], b[1:0]};
  endfunction

  task automatic chk(input logic [10:0] got, input logic [10:0] want, input string what);
    n_compared++;
    if (got !== want)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic wait_empty();
    for (int i = 0; i < 300 && exp_q.size() != 0; i++)
      @(negedge sys_clk);
    chk({10'h0, exp_q.size() == 0}, 11'h1, "updates missing");
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk)
    cfg_ready <= !stall && (rnd() & 32'h3) != 32'h0;

  always @(negedge sys_clk)
    if (cfg_valid_r === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(11'h1, 11'h0, "unexpected update");
      else
        chk(seen, exp_q.pop_front(), "settings");
    end

  // Link outputs at each conversion start and after each deselect
  always @(posedge conv_start_o)
  begin
    #1;
    n_conv++;
    chk({7'h0, dout_oe, dout_o, track_o, hold_o}, 11'h009, "start outputs");
  end

  always @(posedge cs_n)
  begin
    #1;
    chk({7'h0, dout_oe, track_o, hold_o, conv_start_o}, 11'h000, "released outputs");
  end

  initial
  begin
    // Scheduled late so the asynchronous link resets see a rising edge
    rst <= 1'b1;
    repeat (20) @(negedge sys_clk);
    chk({pos_chan_r, neg_common_r, polarity_select_r, input_config_select_r, power_clock_mode_r, overflow_r,
         dout_oe, cfg_valid_r}, {3'h0, 1'b1, 1'b0, 1'b1, 2'h2, 3'h0}, "reset values");
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    for (int b = 128; b < 256; b++)
    begin
      q = {b[7:0]};
      exp_q.push_back(dec(b[7:0]));
      i_host.frame(q, rnd() % 5, 0);
    end
    wait_empty();
    chk(11'(n_conv), 11'h080, "conversion starts");
    $display("test all codes done");
    q = {8'h80};
    for (int c = 1; c < 8; c++)
      i_host.frame(q, 2, c);
    repeat (40) @(negedge sys_clk);
    chk(seen, dec(8'hFF), "abort changed settings");
    chk(11'(n_conv), 11'h080, "abort started conversion");
    $display("test abort done");
    stall = 1'b1;
    q = {};
    for (int i = 0; i < 17; i++)
    begin
      r = rnd();
      q.push_back({1'b1, r[6:0]});
      if (i < 16)
        exp_q.push_back(dec({1'b1, r[6:0]}));
    end
    i_host.frame(q, 1, 0);
    repeat (20) @(negedge sys_clk);
    chk({10'h0, overflow_r}, 11'h1, "overflow flag");
    stall = 1'b0;
    wait_empty();
    chk(11'(n_conv), 11'h091, "conversion starts");
    $display("test overflow done");
    give_verdict();
  end

  initial
  begin
    #1500000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
